// >>> rtl/dicc_top.sv
// dual integrator conversion control with config port and apb status
// Function
// R1 - two integrators per channel; 64 integrators muxed onto 16 converters
// R2 - one side converts while the other side's 32 integrators integrate
// R3 - results go to the serial output register; ready flag low when valid
// R4 - host switches side select near a rising master clock edge
// R5 - after conversion a side resets, then waits until integration starts
// R6 - side select rising edge starts side A integration
// R7 - side select falling edge stops A, starts B, converts A
// R8 - side B converts and resets while A integrates
// R9 - three-bit range code picks one feedback capacitor for all integrators
// R10 - host holds side select low and pulses reset before config write
// R11 - host sends config data most significant bit first
// R12 - config bits are captured on falling config clock edges
// R13 - host always sends all 12 config bits
// R14 - readback is offered only right after a completed config write
// R15 - readback shifts config, revision, then test pattern on readout clock
// R16 - 20-bit format pattern field is 304 bits, zero but last 72
// R17 - readback sequence sent twice, then chained data passes through
// R18 - test pattern constant chosen by the format bit
// R19 - host pulses side select to return to normal conversion
// R20 - host keeps master clock running during config access
// R21 - side select low integrates side B, high integrates side A
// R22 - range code sits in the top three config bits
// R23 - host waits 2 us after reset release before first config clock
// R24 - host waits 2 us between config write and readback
// R25 - host writes zero into unused config bits
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module dicc_top
  import dicc_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h1  // arbitrary revision code
) (
  input  wire logic                  I_CLOCK,
  input  wire logic                  I_RST_N,
  input  wire logic                  I_PSEL,
  input  wire logic                  I_PENABLE,
  input  wire logic                  I_PWRITE,
  input  wire logic [7:0]            I_PADDR,
  input  wire logic [31:0]           I_PWDATA,
  output logic      [31:0]           O_PRDATA,
  output logic                       O_PREADY,
  output logic                       O_PSLVERR,
  input  wire logic                  I_SIDE_SELECT,
  input  wire logic                  I_CHIP_RESET_N,
  input  wire logic                  I_CFG_CLOCK,
  input  wire logic                  I_CFG_DATA,
  input  wire logic                  I_READOUT_SHIFT_CLOCK,
  input  wire logic                  I_SERIAL_IN,
  input  wire logic [dicc_pkg::RES_W-1:0] I_SIDE_SELECT_DATA,
  input  wire logic                  I_SIDE_SELECT_VALID,
  output logic                       O_SERIAL_OUT,
  output logic                       O_RESULT_READY_N,
  output logic                       O_SIDE_A_INPUT_SWITCH,
  output logic                       O_SIDE_B_INPUT_SWITCH,
  output logic [1:0]                 O_SIDE_A_PHASE,
  output logic [1:0]                 O_SIDE_B_PHASE,
  output logic                       O_SIDE_SELECT_BUSY,
  output logic                       O_SIDE_SELECT_SIDE_B,
  output logic                       O_MUX_UPPER_HALF,
  output logic [2:0]                 O_RANGE,
  output logic                       O_FORMAT_20
);

  import dicc_pkg::*;

  // synchronised pins and their previous values
  logic [5:0]        pin_s;
  logic [5:0]        pin_q;
  logic              ss_rise;
  logic              ss_fall;
  logic              crst_rel;
  logic              crst_low;
  logic              cclk_fall;
  logic              rclk_rise;
  dicc_phase_t       phase [2];
  logic [1:0]        start_ev;
  logic [1:0]        stop_ev;
  dicc_mode_t        mode;
  logic              run;
  logic              side_select_busy;
  logic              side_select_side;
  logic [4:0]        side_select_cnt;
  logic              side_select_done;
  logic [RES_W-1:0]  result_mem [CHANNELS];
  logic              result_ready_n;
  logic [4:0]        rd_word;
  logic [4:0]        rd_bit;
  logic [4:0]        rd_last_bit;
  logic [11:0]       cfg;
  logic [11:0]       shadow;
  logic [3:0]        bitcnt;
  logic [8:0]        rb_idx;
  logic [8:0]        seq_last;
  logic [1:0]        rb_rep;
  logic              serial_out;

  dicc_sync #(
    .WIDTH     (6),
    .RESET_VAL (PIN_RESET)
  ) u_sync (
    .i_clock (I_CLOCK),
    .i_rst_n (I_RST_N),
    .i_async ({I_SERIAL_IN, I_READOUT_SHIFT_CLOCK, I_CFG_DATA, I_CFG_CLOCK,
               I_CHIP_RESET_N, I_SIDE_SELECT}),
    .o_sync  (pin_s)
  );

  // previous synchronised levels for edge detection
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
      pin_q <= PIN_RESET;
    else
      pin_q <= pin_s;
  end

  // pin edges; master clock times all sequencing
  assign ss_rise   = pin_s[0] & ~pin_q[0];
  assign ss_fall   = ~pin_s[0] & pin_q[0];
  assign crst_rel  = pin_s[1] & ~pin_q[1];
  assign crst_low  = ~pin_s[1];
  assign cclk_fall = ~pin_s[2] & pin_q[2];              // see R12
  assign rclk_rise = pin_s[4] & ~pin_q[4];              // see R15

  // rising edge starts A and stops B, falling edge the reverse
  assign start_ev = {ss_fall, ss_rise} & {2{run && mode == MD_NORMAL}};  // see R21
  assign stop_ev  = {ss_rise, ss_fall} & {2{mode == MD_NORMAL}};

  // per-side integrator sequencer: reset, wait, integrate, convert
  genvar s;
  generate
    for (s = 0; s < 2; s++)
    begin : g_side
      logic [3:0] rst_cnt;
      always_ff @(posedge I_CLOCK)
      begin
        if (!I_RST_N || crst_low)
        begin
          phase[s] <= PH_RESET;
          rst_cnt  <= 4'h0;
        end
        else
        begin
          unique case (phase[s])
            PH_RESET:                                     // see R5
            begin
              if (rst_cnt == 4'(RESET_CYCLES - 1))
              begin
                phase[s] <= PH_WAIT;
                rst_cnt  <= 4'h0;
              end
              else
                rst_cnt <= rst_cnt + 4'h1;
            end
            PH_WAIT:
              if (start_ev[s])
                phase[s] <= PH_INTEG;                     // see R6
            PH_INTEG:
              if (stop_ev[s])
                phase[s] <= PH_SIDE_SELECT;                      // see R7
            PH_SIDE_SELECT:
              if (side_select_done && side_select_side == 1'(s))
                phase[s] <= PH_RESET;                     // see R8
          endcase
        end
      end
    end
  endgenerate

  // converter share: 32 results per side, two rounds of 16 converters
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RST_N || crst_low)
    begin
      side_select_busy <= 1'b0;
      side_select_side <= 1'b0;
      side_select_cnt  <= 5'h00;
    end
    else if (stop_ev[0] && phase[0] == PH_INTEG)
    begin
      side_select_busy <= 1'b1;                                  // see R2
      side_select_side <= 1'b0;
      side_select_cnt  <= 5'h00;
    end
    else if (stop_ev[1] && phase[1] == PH_INTEG)
    begin
      side_select_busy <= 1'b1;
      side_select_side <= 1'b1;
      side_select_cnt  <= 5'h00;
    end
    else if (side_select_busy && I_SIDE_SELECT_VALID)
    begin
      side_select_cnt <= side_select_cnt + 5'h01;                       // see R1
      if (side_select_done)
        side_select_busy <= 1'b0;
    end
  end

  assign side_select_done = side_select_busy && I_SIDE_SELECT_VALID && side_select_cnt == 5'(CHANNELS - 1);

  // result storage for the side being converted
  always_ff @(posedge I_CLOCK)
  begin
    if (side_select_busy && I_SIDE_SELECT_VALID)
      result_mem[side_select_cnt] <= I_SIDE_SELECT_DATA;                // see R3
  end

  // configuration write, commit only on the twelfth bit
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RST_N || crst_low)
    begin
      cfg    <= CFG_RESET;
      shadow <= 12'h000;
      bitcnt <= 4'h0;
    end
    else if (mode == MD_CFG_WRITE && cclk_fall)
    begin
      shadow <= {shadow[10:0], pin_s[3]};                 // see R12
      bitcnt <= bitcnt + 4'h1;
      if (bitcnt == 4'(CFG_BITS - 1))
        cfg <= {shadow[10:0], pin_s[3]};                  // see R14
    end
  end

  // mode: reset release with side select low opens config write
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
      mode <= MD_NORMAL;
    else if (crst_rel && !pin_s[0])
      mode <= MD_CFG_WRITE;
    else if (ss_rise)
      mode <= MD_NORMAL;
    else if (mode == MD_CFG_WRITE && cclk_fall && bitcnt == 4'(CFG_BITS - 1))
      mode <= MD_CFG_DONE;
    else if (mode == MD_CFG_DONE && rclk_rise)
      mode <= MD_READBACK;                                // see R14
  end

  // one readback bit: config, revision, then right-aligned pattern
  function automatic logic rb_bit(input logic [8:0] idx, input logic [11:0] c);
    int   i;
    int   k;
    logic f;
    i = int'(idx);
    f = c[FORMAT_BIT];
    k = (f ? PATFIELD20 : PATFIELD16) - 1 - (i - CFG_BITS - REV_BITS);
    if (i < CFG_BITS)
      rb_bit = c[CFG_BITS - 1 - i];
    else if (i < CFG_BITS + REV_BITS)
      rb_bit = REVISION[CFG_BITS + REV_BITS - 1 - i];
    else if (k < (f ? PAT20_LEN : PAT16_LEN))
      rb_bit = f ? PAT20[k] : PAT16[k];                   // see R18
    else
      rb_bit = 1'b0;                                      // see R16
  endfunction : rb_bit

  assign seq_last    = cfg[FORMAT_BIT] ? 9'(SEQ20 - 1) : 9'(SEQ16 - 1);
  assign rd_last_bit = cfg[FORMAT_BIT] ? 5'(RES_W - 1) : 5'(RES16_W - 1);

  // serial output path for readback and for result readout
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
    begin
      serial_out     <= 1'b0;
      rb_idx         <= 9'h000;
      rb_rep         <= 2'h0;
      rd_word        <= 5'h00;
      rd_bit         <= 5'h00;
      result_ready_n <= 1'b1;
    end
    else if (mode != MD_NORMAL)
    begin
      if (mode == MD_CFG_WRITE)
      begin
        rb_idx <= 9'h000;
        rb_rep <= 2'h0;
      end
      else if (rclk_rise && rb_rep < 2'(RB_REPEATS))
      begin
        serial_out <= rb_bit(rb_idx, cfg);                // see R15
        rb_idx     <= (rb_idx == seq_last) ? 9'h000 : rb_idx + 9'h001;
        if (rb_idx == seq_last)
          rb_rep <= rb_rep + 2'h1;                        // see R17
      end
      else if (rclk_rise)
        serial_out <= pin_s[5];                           // see R17
    end
    else if (side_select_done)
    begin
      result_ready_n <= 1'b0;                             // see R3
      rd_word        <= 5'h00;
      rd_bit         <= 5'h00;
    end
    else if (rclk_rise)
    begin
      if (!result_ready_n)
      begin
        serial_out <= result_mem[rd_word][5'(RES_W - 1) - rd_bit];
        rd_bit     <= (rd_bit == rd_last_bit) ? 5'h00 : rd_bit + 5'h01;
        if (rd_bit == rd_last_bit)
        begin
          rd_word <= rd_word + 5'h01;
          if (rd_word == 5'(CHANNELS - 1))
            result_ready_n <= 1'b1;
        end
      end
      else
        serial_out <= pin_s[5];
    end
  end

  // apb control register
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
      run <= CTRL_RESET;
    else if (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == OFS_CTRL)
      run <= I_PWDATA[0];
  end

  // apb read data and error, prepared in the setup cycle
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
    begin
      O_PRDATA  <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end
    else if (I_PSEL && !I_PENABLE)
    begin
      O_PSLVERR <= 1'b0;
      unique case (I_PADDR)
        OFS_CTRL:   O_PRDATA <= {31'h0, run};
        OFS_STATUS: O_PRDATA <= {23'h0, side_select_side, side_select_busy, ~result_ready_n,
                                 mode, phase[1], phase[0]};
        OFS_CONFIG: O_PRDATA <= {20'h0, cfg};
        default:
        begin
          O_PRDATA  <= 32'h0000_0000;
          O_PSLVERR <= 1'b1;
        end
      endcase
    end
  end

  // outputs
  assign O_PREADY              = 1'b1;
  assign O_SERIAL_OUT          = serial_out;
  assign O_RESULT_READY_N      = result_ready_n;
  assign O_SIDE_A_INPUT_SWITCH = (phase[0] == PH_INTEG);  // see R6
  assign O_SIDE_B_INPUT_SWITCH = (phase[1] == PH_INTEG);
  assign O_SIDE_A_PHASE        = phase[0];
  assign O_SIDE_B_PHASE        = phase[1];
  assign O_SIDE_SELECT_BUSY           = side_select_busy;
  assign O_SIDE_SELECT_SIDE_B         = side_select_side;               // see R7
  assign O_MUX_UPPER_HALF      = side_select_cnt[4];             // see R1
  assign O_RANGE               = cfg[RANGE_MSB:RANGE_LSB]; // see R9 see R22
  assign O_FORMAT_20           = cfg[FORMAT_BIT];

  // checks
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  a_side_a_start: assert property (                       // see R6
    start_ev[0] && phase[0] == PH_WAIT && pin_s[1] |=> O_SIDE_A_INPUT_SWITCH)
    else $error("side A did not start integrating");
  a_side_a_stop: assert property (                        // see R7
    stop_ev[0] && phase[0] == PH_INTEG && pin_s[1]
    |=> phase[0] == PH_SIDE_SELECT && side_select_busy && !O_SIDE_SELECT_SIDE_B
        && (O_SIDE_B_INPUT_SWITCH || !$past(run) || $past(phase[1]) != PH_WAIT))
    else $error("side A stop did not hand over");
  a_side_b_start: assert property (                       // see R8
    start_ev[1] && phase[1] == PH_WAIT && pin_s[1] |=> phase[1] == PH_INTEG)
    else $error("side B did not start integrating");
  a_one_integ: assert property (                          // see R2
    !(phase[0] == PH_INTEG && phase[1] == PH_INTEG))
    else $error("both sides integrating");
  a_reset_len: assert property (                          // see R5
    side_select_done && !side_select_side && pin_s[1]
    |=> (phase[0] == PH_RESET && pin_s[1]) [*6] ##1 phase[0] == PH_WAIT)
    else $error("side A reset length wrong");
  a_ready_low: assert property (                          // see R3
    side_select_done && mode == MD_NORMAL |=> !O_RESULT_READY_N)
    else $error("ready flag not set after conversion");
  a_cfg_shift: assert property (                          // see R12
    mode == MD_CFG_WRITE && cclk_fall && pin_s[1] |=> shadow[0] == $past(pin_s[3]))
    else $error("config bit not captured");
  a_cfg_commit: assert property (                         // see R14
    mode == MD_CFG_WRITE && cclk_fall && bitcnt == 4'hB && pin_s[1] && !crst_rel
    && !ss_rise |=> cfg[0] == $past(pin_s[3]) && mode == MD_CFG_DONE)
    else $error("config word not committed");
  a_rb_wrap: assert property (                            // see R17
    mode == MD_READBACK && rclk_rise && rb_idx == seq_last && rb_rep == 2'h0
    && !ss_rise && !crst_rel |=> rb_rep == 2'h1 && rb_idx == 9'h000)
    else $error("readback did not repeat");
  a_rb_zero: assert property (                            // see R16
    mode == MD_READBACK && rclk_rise && rb_rep < 2'h2 && rb_idx == 9'h010
    && !ss_rise && !crst_rel |=> !O_SERIAL_OUT)
    else $error("pattern field head not zero");
  a_rb_tail: assert property (                            // see R18
    mode == MD_READBACK && rclk_rise && rb_rep < 2'h2 && rb_idx == seq_last
    && !ss_rise && !crst_rel |=> O_SERIAL_OUT == O_FORMAT_20)
    else $error("pattern last bit wrong");

  c_side_select_done: cover property (side_select_done);
  c_cfg_done:  cover property (mode == MD_CFG_WRITE ##1 mode == MD_CFG_DONE);
  c_rb_twice:  cover property (rb_rep == 2'h2);
  c_readout:   cover property ($rose(O_RESULT_READY_N));

endmodule : dicc_top

// >>> rtl/dicc_pkg.sv
// constants, encodings and types shared by the conversion control block
package dicc_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned RESET_TIME_NS = 24;
  localparam int unsigned RESET_CYCLES  = (RESET_TIME_NS * CLK_MHZ + 999) / 1000;

  // channel structure
  localparam int unsigned CHANNELS   = 32;
  localparam int unsigned CONVERTERS = 16;
  localparam int unsigned RES_W      = 20;
  localparam int unsigned RES16_W    = 16;

  // configuration word layout
  localparam int unsigned   CFG_BITS   = 12;
  localparam int unsigned   REV_BITS   = 4;
  localparam int unsigned   RANGE_MSB  = 11;
  localparam int unsigned   RANGE_LSB  = 9;
  localparam int unsigned   FORMAT_BIT = 8;
  localparam logic [11:0]   CFG_RESET  = 12'hF00;

  // readback pattern and sequence lengths
  localparam logic [71:0] PAT16      = 72'h0000_30F066012480F6;
  localparam logic [71:0] PAT20      = 72'h30F066012480F69055;
  localparam int unsigned PAT16_LEN  = 56;
  localparam int unsigned PAT20_LEN  = 72;
  localparam int unsigned PATFIELD16 = 240;
  localparam int unsigned PATFIELD20 = 304;
  localparam int unsigned SEQ16      = CFG_BITS + REV_BITS + PATFIELD16;
  localparam int unsigned SEQ20      = CFG_BITS + REV_BITS + PATFIELD20;
  localparam int unsigned RB_REPEATS = 2;

  // apb register map and reset values
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_STATUS = 8'h04;
  localparam logic [7:0]  OFS_CONFIG = 8'h08;
  localparam logic        CTRL_RESET = 1'h1;

  // synchroniser reset levels, pin order {sin, rclk, cdat, cclk, crst_n, side}
  localparam logic [5:0]  PIN_RESET  = 6'h02;

  // integrator phase of one side, gray along reset-wait-integrate-convert
  typedef enum logic [1:0] {
    PH_RESET = 2'b00,
    PH_WAIT  = 2'b01,
    PH_INTEG = 2'b11,
    PH_SIDE_SELECT  = 2'b10
  } dicc_phase_t;

  // operating mode of the serial side
  typedef enum logic [1:0] {
    MD_NORMAL    = 2'b00,
    MD_CFG_WRITE = 2'b01,
    MD_CFG_DONE  = 2'b11,
    MD_READBACK  = 2'b10
  } dicc_mode_t;

endpackage : dicc_pkg

// >>> rtl/dicc_sync.sv
// two-flop synchronisers for pins from outside the clock domain
`timescale 1ns/1ps
module dicc_sync #(
  parameter int unsigned        WIDTH     = 1,
  parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  // one meta flop and one output flop per bit
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic meta;
      always_ff @(posedge i_clock)
      begin
        if (!i_rst_n)
        begin
          meta      <= RESET_VAL[g];
          o_sync[g] <= RESET_VAL[g];
        end
        else
        begin
          meta      <= i_async[g];
          o_sync[g] <= meta;
        end
      end
    end
  endgenerate

endmodule : dicc_sync

// >>> verif/dicc_host.sv
// host model: side select, chip reset, config port, readout clock, results
`timescale 1ns/1ps
module dicc_host
  import dicc_pkg::*;
(
  input  wire logic                  i_clock,
  input  wire logic                  i_serial_out,
  output logic                       o_side,
  output logic                       o_chip_rst_n,
  output logic                       o_cfg_clock,
  output logic                       o_cfg_data,
  output logic                       o_rd_clock,
  output logic [dicc_pkg::RES_W-1:0] o_side_select_data,
  output logic                       o_side_select_valid
);
  // idle levels; shift clocks stand low outside frames
  initial
  begin
    o_side = 1'b0;
    o_chip_rst_n = 1'b1;
    o_cfg_clock = 1'b0;
    o_cfg_data = 1'b0;
    o_rd_clock = 1'b0;
    o_side_select_data = '0;
    o_side_select_valid = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask : tick

  // side select moves only right after a rising master clock edge
  task automatic side(input logic lvl);
    @(posedge i_clock);
    o_side <= lvl;
  endtask : side

  // converter results, one per valid pulse; bus scrambled between them
  task automatic results(input int first, input int count);
    for (int k = first; k < first + count; k++)
    begin
      @(posedge i_clock);
      o_side_select_valid <= 1'b1;
      o_side_select_data <= 20'hC3A50 + 20'(k);
      @(posedge i_clock);
      o_side_select_valid <= 1'b0;
      o_side_select_data <= ~o_side_select_data;
    end
  endtask : results

  // full 12-bit write after a reset strobe with side select low
  task automatic cfg_write(input logic [CFG_BITS-1:0] word);
    side(1'b0);
    tick(4);
    o_chip_rst_n <= 1'b0;
    tick(250);
    o_chip_rst_n <= 1'b1;
    tick(500);
    for (int i = CFG_BITS - 1; i >= 0; i--)
    begin
      o_cfg_data <= word[i];
      tick(4);
      o_cfg_clock <= 1'b1;
      tick(8);
      o_cfg_clock <= 1'b0;
      tick(4);
    end
    o_cfg_data <= ~o_cfg_data;
  endtask : cfg_write

  // one readout clock period, output sampled at the end of the high phase
  task automatic shift_out(output logic b);
    o_rd_clock <= 1'b1;
    tick(8);
    b = i_serial_out;
    o_rd_clock <= 1'b0;
    tick(8);
  endtask : shift_out
endmodule : dicc_host

// >>> verif/tb_dicc_top.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ps
module tb_dicc_top;
  import dicc_pkg::*;

  localparam logic [3:0] REV = 4'h6;  // arbitrary revision code
  logic clk;
  logic rst_n;
  logic psel;
  logic pen;
  logic pwr;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic perr;
  logic side;
  logic crst_n;
  logic cclk;
  logic cdat;
  logic rclk;
  logic sin;
  logic sout;
  logic rdy_n;
  logic sw_a;
  logic sw_b;
  logic [1:0] ph_a;
  logic [1:0] ph_b;
  logic busy;
  logic cside;
  logic mux_hi;
  logic [2:0] rng;
  logic fmt;
  logic [RES_W-1:0] cdata;
  logic cvalid;
  logic [31:0] rd;
  logic err;
  logic b;
  int num_errors;
  int comparisons;

  dicc_top #(.REVISION(REV)) i_dut (
    .I_CLOCK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(perr), .I_SIDE_SELECT(side),
    .I_CHIP_RESET_N(crst_n), .I_CFG_CLOCK(cclk), .I_CFG_DATA(cdat),
    .I_READOUT_SHIFT_CLOCK(rclk), .I_SERIAL_IN(sin), .I_SIDE_SELECT_DATA(cdata),
    .I_SIDE_SELECT_VALID(cvalid), .O_SERIAL_OUT(sout), .O_RESULT_READY_N(rdy_n),
    .O_SIDE_A_INPUT_SWITCH(sw_a), .O_SIDE_B_INPUT_SWITCH(sw_b),
    .O_SIDE_A_PHASE(ph_a), .O_SIDE_B_PHASE(ph_b), .O_SIDE_SELECT_BUSY(busy),
    .O_SIDE_SELECT_SIDE_B(cside), .O_MUX_UPPER_HALF(mux_hi), .O_RANGE(rng),
    .O_FORMAT_20(fmt)
  );

  dicc_host i_host (
    .i_clock(clk), .i_serial_out(sout), .o_side(side), .o_chip_rst_n(crst_n),
    .o_cfg_clock(cclk), .o_cfg_data(cdat), .o_rd_clock(rclk),
    .o_side_select_data(cdata), .o_side_select_valid(cvalid)
  );

  // master clock, 4 ns period, kept running throughout
  always #2 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // expected readback bit at position i of one sequence
  function automatic logic rb_bit(input logic [11:0] w, input int i);
    int fl;
    int pl;
    logic [71:0] pat;
    fl = w[FORMAT_BIT] ? PATFIELD20 : PATFIELD16;
    pl = w[FORMAT_BIT] ? PAT20_LEN : PAT16_LEN;
    pat = w[FORMAT_BIT] ? PAT20 : PAT16;
    if (i < CFG_BITS)
      return w[CFG_BITS-1-i];
    if (i < CFG_BITS + REV_BITS)
      return REV[CFG_BITS+REV_BITS-1-i];
    i = i - CFG_BITS - REV_BITS;
    if (i < fl - pl)
      return 1'b0;
    return pat[fl-1-i];
  endfunction : rb_bit

  task automatic test_regs;
    repeat (10) @(posedge clk);
    apb(1'b0, OFS_CONFIG, 32'h0);
    chk(rd, {20'h0, CFG_RESET});
    apb(1'b1, OFS_CONFIG, 32'h0);
    apb(1'b0, OFS_CONFIG, 32'h0);
    chk(rd, {20'h0, CFG_RESET});
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    chk({28'h0, rng, fmt}, 32'hF);
    // integration starts are held off while the run bit is clear
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h0);
    i_host.side(1'b1);
    repeat (6) @(posedge clk);
    chk({ph_a, sw_a, sw_b}, {PH_WAIT, 2'b00});
    i_host.side(1'b0);
    repeat (6) @(posedge clk);
    chk({ph_a, ph_b, busy}, {PH_WAIT, PH_WAIT, 1'b0});
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1);
  endtask : test_regs

  task automatic test_conversion;
    logic [19:0] w;
    i_host.side(1'b1);
    repeat (6) @(posedge clk);
    chk({ph_a, sw_a, sw_b}, {PH_INTEG, 2'b10});
    i_host.side(1'b0);
    repeat (6) @(posedge clk);
    chk({ph_a, ph_b, sw_a, sw_b}, {PH_SIDE_SELECT, PH_INTEG, 2'b01});
    chk({busy, cside}, 32'h2);
    i_host.results(0, 16);
    repeat (2) @(posedge clk);
    chk(mux_hi, 32'h1);
    i_host.results(16, 16);
    repeat (2) @(posedge clk);
    chk({rdy_n, ph_a, ph_b}, {1'b0, PH_RESET, PH_INTEG});
    repeat (7) @(posedge clk);
    chk(ph_a, PH_WAIT);
    for (int i = 0; i < 20; i++)
    begin
      i_host.shift_out(b);
      w = {w[18:0], b};
    end
    chk(w, 20'hC3A50);
    i_host.side(1'b1);
    repeat (6) @(posedge clk);
    chk({ph_a, ph_b, cside}, {PH_INTEG, PH_SIDE_SELECT, 1'b1});
    i_host.results(0, 32);
    repeat (9) @(posedge clk);
    chk({ph_b, rdy_n}, {PH_WAIT, 1'b0});
  endtask : test_conversion

  task automatic readback(input logic [11:0] word);
    int len;
    len = word[FORMAT_BIT] ? SEQ20 : SEQ16;
    repeat (500) @(posedge clk);
    for (int i = 0; i < 2 * len; i++)
    begin
      i_host.shift_out(b);
      chk(b, rb_bit(word, i % len));
    end
    for (int i = 0; i < 6; i++)
    begin
      sin <= (i < 3);
      i_host.shift_out(b);
      if (i % 3 == 2)
        chk(b, sin);
    end
  endtask : readback

  task automatic test_config;
    logic [11:0] word;
    for (int r = 0; r < 8; r++)
    begin
      word = {r[2:0], r[0], 8'h00};
      i_host.cfg_write(word);
      repeat (4) @(posedge clk);
      chk({rng, fmt}, {r[2:0], r[0]});
      apb(1'b0, OFS_CONFIG, 32'h0);
      chk(rd, word);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[5:4], MD_CFG_DONE);
      if (r == 4 || r == 5)
        readback(word);
    end
    i_host.side(1'b1);
    repeat (6) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[5:4], MD_NORMAL);
  endtask : test_config

  // watchdog: the whole run needs about 28000 cycles
  initial
  begin
    repeat (90000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  // reset, then the scenarios in turn
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sin = 1'b0;
    num_errors = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    test_regs();
    test_conversion();
    test_config();
    give_verdict();
  end
endmodule : tb_dicc_top
